// *** hdl/fdcg_pkg.sv ***
`default_nettype none
package fdcg_pkg;
   // Clock rate and timing figures
   localparam int CLK_MHZ = 200;
   localparam int MOTOR_MS = 3000;
   localparam int MOTOR_CYC = MOTOR_MS * 1000 * CLK_MHZ;
   localparam int WD_TICK_NS = 1000;
   localparam int WD_TICK_CYC = (WD_TICK_NS * CLK_MHZ) / 1000;
   localparam int WD_LIMIT_US = 1024;
   localparam int WD_LIMIT_TICKS = (WD_LIMIT_US * 1000) / WD_TICK_NS;
   localparam int WD_SHORT_TICKS = 2;
   // Fixed precompensation amount, applied inside the controller chip
   localparam int PRECOMP_NS = 125;

   // Port map
   localparam logic [7:0] PORT_NMI = 8'hE4;
   localparam logic [7:0] PORT_FDC_BASE = 8'hF0;
   localparam logic [7:0] PORT_DRV = 8'hF4;
   localparam int FDC_SEL_W = 2;

   // Mask register layout (data bits 7 and 6)
   localparam int MASK_FDC_BIT = 7;
   localparam int MASK_MOT_BIT = 6;
   localparam logic [1:0] MASK_RESET = 2'h0;

   // Status byte layout, all active low
   localparam int ST_IRQ_BIT = 7;
   localparam int ST_MOT_BIT = 6;
   localparam int ST_RST_BIT = 5;
   localparam logic [4:0] ST_RSVD = 5'h00;

   // Drive select latch layout
   localparam int DRV_SEL_W = 4;
   localparam int DRV_SIDE_BIT = 4;
   localparam int DRV_PCOMP_BIT = 5;
   localparam int DRV_WAIT_BIT = 6;
   localparam int DRV_MFM_BIT = 7;
   localparam logic [7:0] DRV_RESET = 8'h00;
endpackage : fdcg_pkg
`default_nettype wire

// *** hdl/fdcg_wait_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface fdcg_wait_if;
   logic start_long;
   logic start_short;
   logic release_req;
   logic busy;
   modport ctl (output start_long, output start_short, output release_req,
                input busy);
   modport tmr (input start_long, input start_short, input release_req,
                output busy);
endinterface : fdcg_wait_if
`default_nettype wire

// *** hdl/fdcg_wait_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module fdcg_wait_timer
   import fdcg_pkg::*;
#(
   parameter int TICK_CYCLES = WD_TICK_CYC,
   parameter int LONG_TICKS = WD_LIMIT_TICKS
)
(
   input wire logic clk,
   input wire logic rst,
   fdcg_wait_if.tmr wif
);
   localparam int PRE_W = $clog2(TICK_CYCLES);
   localparam int TCK_W = $clog2(LONG_TICKS) + 1;

   typedef enum logic [1:0]
   {
      W_IDLE = 2'b00,
      W_LONG = 2'b01,
      W_SHORT = 2'b10
   } fdcg_wstate_e;

   fdcg_wstate_e st_q;
   logic [PRE_W-1:0] pre_q;
   logic [TCK_W-1:0] ticks_q;
   logic tick;
   logic long_end;
   logic short_end;

   ////////////////////////////////////////////////////////////////////////
   // Watchdog time base, only runs while a wait is held
   assign tick = (pre_q == PRE_W'(TICK_CYCLES - 1));
   assign long_end = tick && (ticks_q == TCK_W'(LONG_TICKS - 1));
   assign short_end = tick && (ticks_q == TCK_W'(WD_SHORT_TICKS - 1));
   assign wif.busy = (st_q != W_IDLE);

   // Prescaler and tick counter restart on every new wait
   always_ff @(posedge clk)
   begin
      if (rst || wif.start_long || wif.start_short || st_q == W_IDLE)
      begin
         pre_q <= '0;
         ticks_q <= '0;
      end
      else if (tick)
      begin
         pre_q <= '0;
         ticks_q <= ticks_q + TCK_W'(1);
      end
      else
      begin
         pre_q <= pre_q + PRE_W'(1);
      end
   end

   // Wait state; a new start always wins over an ending wait
   always_ff @(posedge clk)
   begin
      if (rst)
         st_q <= W_IDLE;
      else if (wif.start_long)
         st_q <= W_LONG;
      else if (wif.start_short)
         st_q <= W_SHORT;
      else
      begin
         unique case (st_q)
            W_IDLE: st_q <= W_IDLE;
            W_LONG:
            begin
               if (wif.release_req || long_end)
                  st_q <= W_IDLE;
            end
            W_SHORT:
            begin
               if (short_end)
                  st_q <= W_IDLE;
            end
            default: st_q <= W_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_long_release: assert property (@(posedge clk) disable iff (rst)
      (st_q == W_LONG && wif.release_req && !wif.start_long
       && !wif.start_short) |=> st_q == W_IDLE)
      else $error("wait not released by request");
   a_watchdog_limit: assert property (@(posedge clk) disable iff (rst)
      (st_q == W_LONG && long_end && !wif.start_long && !wif.start_short)
      |=> st_q == W_IDLE)
      else $error("watchdog did not end wait");
   a_short_end: assert property (@(posedge clk) disable iff (rst)
      (st_q == W_SHORT && short_end && !wif.start_long && !wif.start_short)
      |=> st_q == W_IDLE)
      else $error("short wait did not end at count two");
   a_short_hold: assert property (@(posedge clk) disable iff (rst)
      (st_q == W_SHORT) |-> ticks_q < TCK_W'(WD_SHORT_TICKS))
      else $error("short wait overran");
   c_short_wait: cover property (@(posedge clk) disable iff (rst)
      st_q == W_SHORT && short_end);
endmodule : fdcg_wait_timer
`default_nettype wire

// *** hdl/fdcg_glue.sv ***
`timescale 1ns/100ps
`default_nettype none
module fdcg_glue
   import fdcg_pkg::*;
#(
   parameter int MOTOR_CYCLES = MOTOR_CYC,
   parameter int TICK_CYCLES = WD_TICK_CYC,
   parameter int LONG_TICKS = WD_LIMIT_TICKS
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic IORD_N,
   input wire logic IOWR_N,
   input wire logic [7:0] CPU_D_I,
   output logic [7:0] CPU_D_O,
   output logic CPU_D_OE,
   input wire logic [7:0] PERIPHERAL_DATA_BUS_I,
   output logic [7:0] PERIPHERAL_DATA_BUS_O,
   output logic PERIPHERAL_DATA_BUS_OE,
   input wire logic INT_STATUS_READ_N,
   input wire logic NMI_STATUS_READ_ALT_N,
   input wire logic SERIAL_READ_STROBE_N,
   input wire logic CONTROLLER_IRQ,
   input wire logic CONTROLLER_DATA_REQUEST,
   output logic DISK_READ_STROBE_N,
   output logic NMI_STATUS_READ_N,
   output logic NMI_MASK_WRITE_N,
   output logic DRIVE_LATCH_WRITE_N,
   output logic FDC_CS_N,
   output logic FDC_WR_N,
   output logic [1:0] FDC_REG_SEL,
   output logic [3:0] DRIVE_SEL,
   output logic SIDE1,
   output logic PRECOMP_EN,
   output logic MFM,
   output logic MOTOR_ON,
   output logic WAIT_N,
   output logic NMI_N
);
   localparam int MOT_W = $clog2(MOTOR_CYCLES);

   logic io_rd;
   logic io_wr;
   logic fdc_hit;
   logic nmi_hit;
   logic drv_hit;
   logic disk_rd_n_d;
   logic fdc_cs_n_d;
   logic nmi_rd_n_d;
   logic mask_wr_n_d;
   logic drv_wr_n_d;
   logic mask_commit;
   logic drv_commit;
   logic motor_expire;
   logic [7:0] status_byte;
   logic [7:0] wr_data_q;
   logic [1:0] mask_q;
   logic [7:0] drv_q;
   logic [MOT_W-1:0] mot_cnt_q;
   logic mot_to_q;
   logic cpu_oe_q;

   fdcg_wait_if wif ();

   ////////////////////////////////////////////////////////////////////////
   // Port decode, controller takes F0 to F3
   assign io_rd = ~IORD_N;
   assign io_wr = ~IOWR_N;
   assign fdc_hit = (ADDR[7:FDC_SEL_W] == PORT_FDC_BASE[7:FDC_SEL_W]);
   assign nmi_hit = (ADDR == PORT_NMI);
   assign drv_hit = (ADDR == PORT_DRV);

   // Next strobe levels; the pins follow one clock later
   always_comb
   begin
      disk_rd_n_d = ~(io_rd & fdc_hit);
      fdc_cs_n_d = ~((io_rd | io_wr) & fdc_hit);
      nmi_rd_n_d = ~(io_rd & nmi_hit);
      mask_wr_n_d = ~(io_wr & nmi_hit);
      drv_wr_n_d = ~(io_wr & drv_hit);
   end

   // Write strobes rise on the cycle their pin goes back high
   assign mask_commit = ~NMI_MASK_WRITE_N & mask_wr_n_d;
   assign drv_commit = ~DRIVE_LATCH_WRITE_N & drv_wr_n_d;

   // Registered decode strobes
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         DISK_READ_STROBE_N <= 1'b1;
         FDC_CS_N <= 1'b1;
         FDC_WR_N <= 1'b1;
         FDC_REG_SEL <= '0;
         NMI_STATUS_READ_N <= 1'b1;
         NMI_MASK_WRITE_N <= 1'b1;
         DRIVE_LATCH_WRITE_N <= 1'b1;
      end
      else
      begin
         DISK_READ_STROBE_N <= disk_rd_n_d;
         FDC_CS_N <= fdc_cs_n_d;
         FDC_WR_N <= ~(io_wr & fdc_hit);
         FDC_REG_SEL <= ADDR[FDC_SEL_W-1:0];
         NMI_STATUS_READ_N <= nmi_rd_n_d;
         NMI_MASK_WRITE_N <= mask_wr_n_d;
         DRIVE_LATCH_WRITE_N <= drv_wr_n_d;
      end
   end

   // Write data held from the strobe until its rising edge
   always_ff @(posedge CLK)
   begin
      if (RST)
         wr_data_q <= '0;
      else if (io_wr)
         wr_data_q <= CPU_D_I;
   end

   ////////////////////////////////////////////////////////////////////////
   // Mask register, cleared so nothing interrupts before software arms it
   always_ff @(posedge CLK)
   begin
      if (RST)
         mask_q <= MASK_RESET;
      else if (mask_commit)
         mask_q <= {wr_data_q[MASK_FDC_BIT], wr_data_q[MASK_MOT_BIT]};
   end

   ////////////////////////////////////////////////////////////////////////
   // Drive select latch; software must load it before any disk work
   always_ff @(posedge CLK)
   begin
      if (RST)
         drv_q <= DRV_RESET;
      else if (drv_commit)
         drv_q <= wr_data_q;
      else if (motor_expire)
         drv_q <= DRV_RESET;
   end

   // Latch fields straight to the drive and controller pins
   assign DRIVE_SEL = drv_q[DRV_SEL_W-1:0];
   assign SIDE1 = drv_q[DRV_SIDE_BIT];
   assign PRECOMP_EN = drv_q[DRV_PCOMP_BIT];
   assign MFM = drv_q[DRV_MFM_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Motor one-shot; spindles are not rated for continuous running
   assign motor_expire = MOTOR_ON && (mot_cnt_q == '0) && !drv_commit;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         MOTOR_ON <= 1'b0;
         mot_cnt_q <= '0;
      end
      else if (drv_commit)
      begin
         MOTOR_ON <= 1'b1;
         mot_cnt_q <= MOT_W'(MOTOR_CYCLES - 1);
      end
      else if (motor_expire)
         MOTOR_ON <= 1'b0;
      else if (MOTOR_ON)
         mot_cnt_q <= mot_cnt_q - MOT_W'(1);
   end

   // Time-out flag sticks until the next drive select write
   always_ff @(posedge CLK)
   begin
      if (RST)
         mot_to_q <= 1'b0;
      else if (motor_expire)
         mot_to_q <= 1'b1;
      else if (drv_commit)
         mot_to_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Wait handshake; each byte still needs a processor port access
   assign wif.start_long = drv_commit & wr_data_q[DRV_WAIT_BIT];
   assign wif.start_short = drv_commit & ~wr_data_q[DRV_WAIT_BIT];
   assign wif.release_req = CONTROLLER_IRQ | CONTROLLER_DATA_REQUEST;

   fdcg_wait_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .LONG_TICKS(LONG_TICKS)
   ) u_wait (
      .clk(CLK),
      .rst(RST),
      .wif(wif.tmr)
   );

   // Reset also drops the wait directly, besides the timer's own reset
   always_ff @(posedge CLK)
   begin
      if (RST)
         WAIT_N <= 1'b1;
      else
         WAIT_N <= ~wif.busy;
   end

   ////////////////////////////////////////////////////////////////////////
   // NMI from controller request and motor time-out, each masked
   always_ff @(posedge CLK)
   begin
      if (RST)
         NMI_N <= 1'b1;
      else
         NMI_N <= ~((mask_q[1] & CONTROLLER_IRQ)
                  | (mask_q[0] & mot_to_q));
   end

   ////////////////////////////////////////////////////////////////////////
   // Status byte, every flag low true, reserved bits zero
   assign status_byte = {~CONTROLLER_IRQ, ~mot_to_q, ~RST, ST_RSVD};

   // Shared transceiver toward the processor
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         cpu_oe_q <= 1'b0;
         CPU_D_O <= '0;
      end
      else
      begin
         cpu_oe_q <= ~(disk_rd_n_d & INT_STATUS_READ_N
                     & NMI_STATUS_READ_ALT_N & SERIAL_READ_STROBE_N
                     & nmi_rd_n_d);
         if (!nmi_rd_n_d)
            CPU_D_O <= status_byte;
         else
            CPU_D_O <= PERIPHERAL_DATA_BUS_I;
      end
   end
   assign CPU_D_OE = cpu_oe_q;

   // Controller buffer: opened by chip select, turned by disk read
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         PERIPHERAL_DATA_BUS_OE <= 1'b0;
         PERIPHERAL_DATA_BUS_O <= '0;
      end
      else
      begin
         PERIPHERAL_DATA_BUS_OE <= ~fdc_cs_n_d & disk_rd_n_d;
         PERIPHERAL_DATA_BUS_O <= CPU_D_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   a_decode_fdc_read: assert property (
      (io_rd && fdc_hit) |=> !DISK_READ_STROBE_N && !FDC_CS_N)
      else $error("controller read not decoded");
   a_xcvr_status: assert property (
      !NMI_STATUS_READ_N |-> CPU_D_OE)
      else $error("transceiver idle during status read");
   a_pbus_direction: assert property (
      PERIPHERAL_DATA_BUS_OE |-> !FDC_CS_N && DISK_READ_STROBE_N)
      else $error("controller buffer driven wrongly");
   a_mask_capture: assert property (
      mask_commit |=> mask_q == {$past(wr_data_q[MASK_FDC_BIT]),
                                 $past(wr_data_q[MASK_MOT_BIT])})
      else $error("mask not captured on strobe rise");
   a_nmi_fdc_gate: assert property (
      (mask_q[1] && CONTROLLER_IRQ) |=> !NMI_N)
      else $error("enabled controller request gave no NMI");
   a_nmi_blocked: assert property (
      (!mask_q[1] && !(mask_q[0] && mot_to_q)) |=> NMI_N)
      else $error("NMI without enabled source");
   a_nmi_motor_gate: assert property (
      (mask_q[0] && mot_to_q) |=> !NMI_N)
      else $error("enabled motor time-out gave no NMI");
   a_status_irq_bit: assert property (
      !nmi_rd_n_d |=> CPU_D_O[ST_IRQ_BIT] == !$past(CONTROLLER_IRQ))
      else $error("status bit 7 wrong");
   a_status_mot_bit: assert property (
      !nmi_rd_n_d |=> CPU_D_O[ST_MOT_BIT] == !$past(mot_to_q))
      else $error("status bit 6 wrong");
   a_motor_expiry: assert property (
      motor_expire |=> DRIVE_SEL == '0 && !MOTOR_ON && mot_to_q)
      else $error("motor expiry did not clear latch");
   a_timeout_sticky: assert property (
      (mot_to_q && !drv_commit) |=> mot_to_q)
      else $error("time-out flag dropped early");
   a_wait_begins: assert property (
      drv_commit |-> ##2 !WAIT_N)
      else $error("drive write raised no wait");

   c_long_release: cover property (
      !WAIT_N ##1 CONTROLLER_DATA_REQUEST ##2 WAIT_N);
   c_motor_nmi: cover property (motor_expire ##[1:4] !NMI_N);
   c_fdc_nmi: cover property (mask_commit ##[1:8] !NMI_N);
endmodule : fdcg_glue
`default_nettype wire

// *** test/fdcg_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fdcg_ctrl_model
(
   input wire logic clk,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [1:0] sel,
   input wire logic [7:0] wdata,
   input wire logic irq_cmd,
   input wire logic drq_set,
   output logic irq,
   output logic controller_data_request,
   output logic [7:0] rdata
);
   logic [7:0] regs_q [4];
   logic [7:0] last_q = 8'h00;
   logic drq_q = 1'h0;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request follows the bench's command level
   assign irq = irq_cmd;
   assign controller_data_request = drq_q;

   // Request holds until the processor touches the data register
   always_ff @(posedge clk)
   begin
      if (!cs_n && sel == 2'h3)
         drq_q <= 1'h0;
      else if (drq_set)
         drq_q <= 1'h1;
   end

   // Register file written only by processor port cycles
   always_ff @(posedge clk)
   begin
      if (!cs_n && !wr_n)
         regs_q[sel] <= wdata;
   end

   // Released bus toggles every cycle so a stale byte never matches
   assign rdata = (!cs_n && !rd_n) ? regs_q[sel] : ~last_q;
   always_ff @(posedge clk)
   begin
      last_q <= rdata;
   end
endmodule : fdcg_ctrl_model
`default_nettype wire

// *** test/floppy_interface_glue_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module floppy_interface_glue_tb_top
   import fdcg_pkg::*;
;
   logic CLK, RST, IORD_N, IOWR_N, CPU_D_OE, PERIPHERAL_DATA_BUS_OE;
   logic [7:0] ADDR, CPU_D_I, CPU_D_O;
   logic [7:0] PERIPHERAL_DATA_BUS_I, PERIPHERAL_DATA_BUS_O;
   logic CONTROLLER_IRQ, CONTROLLER_DATA_REQUEST, DISK_READ_STROBE_N;
   logic NMI_STATUS_READ_N, NMI_MASK_WRITE_N, DRIVE_LATCH_WRITE_N;
   logic FDC_CS_N, FDC_WR_N, SIDE1, PRECOMP_EN, MFM, MOTOR_ON, WAIT_N, NMI_N;
   logic [1:0] FDC_REG_SEL, soe;
   logic [3:0] DRIVE_SEL;
   logic [2:0] ext;
   logic irq_cmd, drq_set;
   logic [7:0] sst, sdo, spo, lat;
   int num_errors = 0;
   int checks = 0;

   ////////////////////////////////////////////////////////////////////////
   // Short counts keep the motor and watchdog runs brief
   fdcg_glue #(.MOTOR_CYCLES(200), .TICK_CYCLES(4), .LONG_TICKS(8)) uut
   (
      .CLK, .RST, .ADDR, .IORD_N, .IOWR_N, .CPU_D_I, .CPU_D_O, .CPU_D_OE,
      .PERIPHERAL_DATA_BUS_I, .PERIPHERAL_DATA_BUS_O, .PERIPHERAL_DATA_BUS_OE,
      .INT_STATUS_READ_N(ext[0]), .NMI_STATUS_READ_ALT_N(ext[1]),
      .SERIAL_READ_STROBE_N(ext[2]), .CONTROLLER_IRQ, .CONTROLLER_DATA_REQUEST,
      .DISK_READ_STROBE_N, .NMI_STATUS_READ_N, .NMI_MASK_WRITE_N,
      .DRIVE_LATCH_WRITE_N, .FDC_CS_N, .FDC_WR_N, .FDC_REG_SEL, .DRIVE_SEL,
      .SIDE1, .PRECOMP_EN, .MFM, .MOTOR_ON, .WAIT_N, .NMI_N
   );

   fdcg_ctrl_model ctrl
   (
      .clk(CLK), .cs_n(FDC_CS_N), .rd_n(DISK_READ_STROBE_N), .wr_n(FDC_WR_N),
      .sel(FDC_REG_SEL), .wdata(PERIPHERAL_DATA_BUS_O), .irq_cmd(irq_cmd),
      .drq_set(drq_set), .irq(CONTROLLER_IRQ), .controller_data_request(CONTROLLER_DATA_REQUEST),
      .rdata(PERIPHERAL_DATA_BUS_I)
   );

   // Latch outputs packed for one compare
   assign lat = {1'h0, MFM, PRECOMP_EN, SIDE1, DRIVE_SEL};

   ////////////////////////////////////////////////////////////////////////
   // Clock at 200 MHz
   initial
   begin
      CLK = 1'h0;
      forever #2.5 CLK = ~CLK;
   end

   task automatic finish_test();
      if (num_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         $display("BAD %s exp %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk

   task automatic rng(input string nm, input int lo, input int hi,
      input int n);
      checks++;
      if (n < lo || n > hi)
      begin
         $display("BAD %s exp %0d..%0d seen %0d", nm, lo, hi, n);
         num_errors++;
      end
   endtask : rng

   // Bounded wait on WAIT_N (w=0) or MOTOR_ON (w=1)
   task automatic wfor(input int w, input logic lvl, input int mx,
      output int n);
      logic s;
      n = 0;
      s = ~lvl;
      while (n <= mx)
      begin
         s = (w == 0) ? WAIT_N : MOTOR_ON;
         if (s === lvl)
            break;
         @(negedge CLK);
         n++;
      end
      checks++;
      if (s !== lvl)
      begin
         $display("BAD wait%0d exp %h seen %h", w, lvl, s);
         num_errors++;
      end
   endtask : wfor

   // Two-cycle port access; snapshot taken while strobes stand
   task automatic acc(input logic wr, input logic [7:0] a,
      input logic [7:0] d);
      @(negedge CLK);
      ADDR = a;
      CPU_D_I = d;
      IORD_N = wr;
      IOWR_N = ~wr;
      repeat (2) @(negedge CLK);
      sst = {DISK_READ_STROBE_N, NMI_STATUS_READ_N, NMI_MASK_WRITE_N,
         DRIVE_LATCH_WRITE_N, FDC_CS_N, FDC_WR_N,
         FDC_CS_N ? 2'h0 : FDC_REG_SEL};
      sdo = CPU_D_O;
      soe = {CPU_D_OE, PERIPHERAL_DATA_BUS_OE};
      spo = PERIPHERAL_DATA_BUS_O;
      IORD_N = 1'h1;
      IOWR_N = 1'h1;
      repeat (3) @(negedge CLK);
   endtask : acc

   // Hang guard, well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge CLK);
      num_errors++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      int n;
      RST = 1'h1;
      IORD_N = 1'h1;
      IOWR_N = 1'h1;
      ADDR = 8'h00;
      CPU_D_I = 8'h00;
      ext = 3'h7;
      irq_cmd = 1'h0;
      drq_set = 1'h0;
      repeat (10) @(negedge CLK);
      RST = 1'h0;
      // Status after reset, then an unmapped port
      acc(1'h0, PORT_NMI, 8'h00);
      chk("strb", 8'hBC, sst);
      chk("stat", 8'hE0, sdo);
      chk("oe", 8'h02, {6'h00, soe});
      chk("rel", 8'h00, {7'h00, CPU_D_OE});
      acc(1'h0, 8'h10, 8'h00);
      chk("strb", 8'hFC, sst);
      chk("oe", 8'h00, {6'h00, soe});
      // Each outside read strobe opens the transceiver
      for (int i = 0; i < 3; i++)
      begin
         ext = ~(3'h1 << i);
         repeat (2) @(negedge CLK);
         chk("ext", 8'h01, {7'h00, CPU_D_OE});
         ext = 3'h7;
      end
      // Controller data register written then read back
      acc(1'h1, PORT_FDC_BASE + 8'h03, 8'h5A);
      chk("strb", 8'hF3, sst);
      chk("oe", 8'h01, {6'h00, soe});
      chk("pdat", 8'h5A, spo);
      acc(1'h0, PORT_FDC_BASE + 8'h03, 8'h00);
      chk("strb", 8'h77, sst);
      chk("rdat", 8'h5A, sdo);
      // Interrupt gating by mask bit 7
      irq_cmd = 1'h1;
      acc(1'h0, PORT_NMI, 8'h00);
      chk("stat", 8'h60, sdo);
      chk("nmi", 8'h01, {7'h00, NMI_N});
      acc(1'h1, PORT_NMI, 8'h3F);
      chk("strb", 8'hDC, sst);
      chk("nmi", 8'h01, {7'h00, NMI_N});
      acc(1'h1, PORT_NMI, 8'h80);
      chk("nmi", 8'h00, {7'h00, NMI_N});
      irq_cmd = 1'h0;
      repeat (2) @(negedge CLK);
      chk("nmi", 8'h01, {7'h00, NMI_N});
      // Drive latch fields and the short wait
      acc(1'h1, PORT_DRV, 8'hB1);
      chk("strb", 8'hEC, sst);
      chk("latch", 8'h71, lat);
      chk("motor", 8'h01, {7'h00, MOTOR_ON});
      wfor(0, 1'h0, 10, n);
      wfor(0, 1'h1, 20, n);
      rng("short", 5, 12, n);
      // Long wait ended by a data request
      acc(1'h1, PORT_DRV, 8'h48);
      chk("latch", 8'h08, lat);
      wfor(0, 1'h0, 10, n);
      drq_set = 1'h1;
      @(negedge CLK);
      drq_set = 1'h0;
      wfor(0, 1'h1, 5, n);
      acc(1'h0, PORT_FDC_BASE + 8'h03, 8'h00);
      // Long wait ended by an interrupt request
      acc(1'h1, PORT_DRV, 8'h48);
      wfor(0, 1'h0, 10, n);
      irq_cmd = 1'h1;
      wfor(0, 1'h1, 5, n);
      irq_cmd = 1'h0;
      // Nobody answers: watchdog must end it
      acc(1'h1, PORT_DRV, 8'h48);
      wfor(0, 1'h0, 10, n);
      wfor(0, 1'h1, 45, n);
      rng("wdog", 28, 40, n);
      // Retriggered motor, expiry and sticky time-out
      acc(1'h1, PORT_NMI, 8'h40);
      acc(1'h1, PORT_DRV, 8'h01);
      repeat (100) @(negedge CLK);
      acc(1'h1, PORT_DRV, 8'h01);
      wfor(1, 1'h0, 210, n);
      rng("motor", 185, 205, n);
      repeat (2) @(negedge CLK);
      chk("latch", 8'h00, lat);
      chk("nmi", 8'h00, {7'h00, NMI_N});
      repeat (20) @(negedge CLK);
      acc(1'h0, PORT_NMI, 8'h00);
      chk("stat", 8'hA0, sdo);
      acc(1'h1, PORT_DRV, 8'h01);
      chk("nmi", 8'h01, {7'h00, NMI_N});
      acc(1'h0, PORT_NMI, 8'h00);
      chk("stat", 8'hE0, sdo);
      // Reset in mid-run drops a long wait and empties the latch
      acc(1'h1, PORT_DRV, 8'h48);
      wfor(0, 1'h0, 10, n);
      RST = 1'h1;
      repeat (2) @(negedge CLK);
      chk("rwait", 8'h01, {7'h00, WAIT_N});
      chk("rlatch", 8'h00, lat);
      chk("rmot", 8'h01, {6'h00, MOTOR_ON, NMI_N});
      RST = 1'h0;
      acc(1'h0, PORT_NMI, 8'h00);
      chk("strb", 8'hBC, sst);
      chk("stat", 8'hE0, sdo);
      finish_test();
   end
endmodule : floppy_interface_glue_tb_top
`default_nettype wire
